// file: hw/bcld_decoder.sv
// Bit, control, literal and table instruction decoder with Wishbone registers
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - 1001 clear, 1000 set, 0111 toggle bit; port targets use pin values
// - Bit write to timer zero register clears assigned prescaler
// - 1011 skips next when selected file bit is zero, flags untouched
// - 1010 skips next when selected file bit is one, flags untouched
// - Skip costs one cycle, two when skipping, extra cycles are no-ops
// - A word led by 1111 executes alone as a no-operation
// - 1110 0ccc conditional branch, two cycles taken; 1101 0 always branches
// - 1110 110s two-word absolute call; 1101 1 relative call; two cycles
// - 1110 1111 two-word absolute jump, first word gives low 8 and second word upper 12 address bits, two cycles
// - 0x03 standby, 0x04 watchdog clear, 0xff software reset, one cycle
// - 0x05 pushes, 0x06 pops the return stack, one cycle each
// - 0x10/0x11 interrupt return, two cycles, low bit selects fast restore
// - 0x12/0x13 subroutine return; 0x0ckk literal return; two cycles
// - Literal add and subtract update all five arithmetic flags
// - Literal and, or, xor update only zero and negative
// - Literal load and multiply change no flags, one cycle
// - 0x010k loads four-bit literal into bank select low bits
// - 1110 1110 00ff loads 12-bit literal into selected pointer
// - 0x08 to 0x0b are table reads with pointer modes, two cycles
// - 0x0c to 0x0f are table writes with pointer modes, two cycles
// - All-zero word is no-op; 0x0007 decimal adjusts, carry only
// - Literal add sums working register and low byte into working register
module bcld_decoder (
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [7:0]         wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [31:0]        wb_dat_i,
   output logic      [31:0]        wb_dat_o,
   output logic                    wb_ack_o,
   input  wire logic [15:0]        instr_i,
   input  wire logic               instr_valid_i,
   input  wire logic [7:0]         file_data_i,
   input  wire logic [7:0]         work_reg_i,
   input  wire logic [4:0]         flags_i,
   output bcld_pkg::bcld_op_type   op_o,
   output logic      [1:0]         cycles_o,
   output logic      [4:0]         flag_mask_o,
   output logic      [7:0]         file_addr_o,
   output logic                    access_bank_o,
   output logic      [2:0]         bit_sel_o,
   output logic      [7:0]         literal_o,
   output logic      [10:0]        offset_o,
   output logic      [19:0]        long_literal_o,
   output logic      [1:0]         sel_o,
   output logic      [7:0]         result_o,
   output logic      [15:0]        product_o,
   output logic      [4:0]         flags_o,
   output logic                    pc_load_o,
   output logic                    skip_o,
   output logic                    pins_read_o,
   output logic                    prescaler_clear_o
);
   import bcld_pkg::*;

   // ****************
   // Register file
   // ****************
   logic [1:0]     ctrl;
   logic [7:0]     timer_adr;
   logic [7:0]     port_adr;
   bcld_state_type state;
   logic           wb_req;

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl      <= CTRL_RST;
         timer_adr <= TIMER_ADR_RST;
         port_adr  <= PORT_ADR_RST;
      end else if (wb_req && wb_we_i) begin
         if (wb_adr_i == ADR_CTRL) begin
            if (wb_sel_i[0]) begin
               ctrl <= wb_dat_i[1:0];
            end
         end else if (wb_adr_i == ADR_SFR) begin
            if (wb_sel_i[0]) begin
               timer_adr <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               port_adr <= wb_dat_i[15:8];
            end
         end
      end
   end

   // Unmapped addresses still acknowledge and read as zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0;
      end else if (wb_req && !wb_we_i) begin
         if (wb_adr_i == ADR_CTRL) begin
            wb_dat_o <= {30'h0, ctrl};
         end else if (wb_adr_i == ADR_SFR) begin
            wb_dat_o <= {16'h0, port_adr, timer_adr};
         end else if (wb_adr_i == ADR_STATUS) begin
            wb_dat_o <= {22'h0, state, cycles_o, op_o};
         end else begin
            wb_dat_o <= 32'h0;
         end
      end
   end

   // ****************
   // Decode
   // ****************
   logic [3:0]  hi;
   logic [7:0]  lo;
   logic        go;
   logic        taken;
   logic        bit_val;
   bcld_op_type d_op;
   logic [1:0]  d_cyc;
   logic [4:0]  d_mask;
   logic        d_pc;
   logic        d_skip;
   logic        d_two;

   assign hi      = instr_i[15:12];
   assign lo      = instr_i[7:0];
   assign go      = instr_valid_i && state == ST_EXEC && ctrl[CTRL_EN];
   assign bit_val = file_data_i[instr_i[11:9]];

   always_comb begin
      case (instr_i[10:9])
         2'b00:   taken = flags_i[FLAG_Z];
         2'b01:   taken = flags_i[FLAG_C];
         2'b10:   taken = flags_i[FLAG_OV];
         default: taken = flags_i[FLAG_N];
      endcase
      taken = taken ^ instr_i[8];
   end

   always_comb begin
      d_op   = OP_OTHER;
      d_cyc  = CYC_ONE;
      d_mask = 5'h0;
      d_pc   = 1'b0;
      d_skip = 1'b0;
      d_two  = 1'b0;
      case (hi)
         HI_BCLR: d_op = OP_BIT_CLR;
         HI_BSET: d_op = OP_BIT_SET;
         HI_BTOG: d_op = OP_BIT_TOG;
         HI_TCLR: begin
            d_op   = OP_TEST_CLR;
            d_skip = !bit_val;
         end
         HI_TSET: begin
            d_op   = OP_TEST_SET;
            d_skip = bit_val;
         end
         HI_CTL: begin
            if (!instr_i[11]) begin
               d_op = OP_BR_COND;
               d_pc = taken;
            end else if (instr_i[11:9] == 3'b110) begin
               d_op  = OP_CALL_ABS;
               d_two = 1'b1;
            end else if (instr_i[11:8] == 4'hf) begin
               d_op  = OP_JUMP_ABS;
               d_two = 1'b1;
            end else if (instr_i[11:6] == 6'h38) begin
               d_op  = OP_PTR_LOAD;
               d_two = 1'b1;
            end
         end
         HI_REL: begin
            d_op = instr_i[11] ? OP_CALL_REL : OP_BR_ALWAYS;
            d_pc = 1'b1;
         end
         HI_EXT: d_op = OP_NOP;
         HI_LIT: begin
            if (instr_i[11:8] == 4'h0) begin
               case (lo)
                  8'h00: d_op = OP_NOP;
                  8'h03: d_op = OP_STANDBY;
                  8'h04: d_op = OP_WDT_CLR;
                  8'hff: d_op = OP_SW_RESET;
                  8'h05: d_op = OP_PUSH;
                  8'h06: d_op = OP_POP;
                  8'h07: begin
                     d_op   = OP_DEC_ADJ;
                     d_mask = MASK_C;
                  end
                  8'h08, 8'h09, 8'h0a, 8'h0b: begin
                     d_op  = OP_TBL_READ;
                     d_cyc = CYC_TWO;
                  end
                  8'h0c, 8'h0d, 8'h0e, 8'h0f: begin
                     d_op  = OP_TBL_WRITE;
                     d_cyc = CYC_TWO;
                  end
                  8'h10, 8'h11: begin
                     d_op = OP_IRQ_RET;
                     d_pc = 1'b1;
                  end
                  8'h12, 8'h13: begin
                     d_op = OP_SUB_RET;
                     d_pc = 1'b1;
                  end
                  default: d_op = OP_OTHER;
               endcase
            end else if (instr_i[11:8] == 4'h1) begin
               if (instr_i[7:4] == 4'h0) begin
                  d_op = OP_BANK_LOAD;
               end
            end else if (instr_i[11:8] == 4'hc) begin
               d_op = OP_RET_LIT;
               d_pc = 1'b1;
            end else if (instr_i[11:8] == 4'hf) begin
               d_op   = OP_LIT_ADD;
               d_mask = MASK_ALL;
            end else if (instr_i[11:8] == 4'h8) begin
               d_op   = OP_LIT_SUB;
               d_mask = MASK_ALL;
            end else if (instr_i[11:8] == 4'hb) begin
               d_op   = OP_LIT_AND;
               d_mask = MASK_ZN;
            end else if (instr_i[11:8] == 4'h9) begin
               d_op   = OP_LIT_OR;
               d_mask = MASK_ZN;
            end else if (instr_i[11:8] == 4'ha) begin
               d_op   = OP_LIT_XOR;
               d_mask = MASK_ZN;
            end else if (instr_i[11:8] == 4'he) begin
               d_op = OP_LIT_LOAD;
            end else if (instr_i[11:8] == 4'hd) begin
               d_op = OP_LIT_MUL;
            end
         end
         default: d_op = OP_OTHER;
      endcase
      // Changing the program counter or skipping costs one no-op cycle
      if (d_pc || d_skip || d_two) begin
         d_cyc = CYC_TWO;
      end
   end

   // ****************
   // Literal and bit data path
   // ****************
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] res;
   logic [4:0] flg;
   logic [8:0] adj;

   always_comb begin
      sum = 9'h0;
      nib = 5'h0;
      adj = {1'b0, work_reg_i};
      res = work_reg_i;
      flg = flags_i;
      case (d_op)
         OP_LIT_ADD: begin
            sum = {1'b0, work_reg_i} + {1'b0, lo};
            nib = {1'b0, work_reg_i[3:0]} + {1'b0, lo[3:0]};
            res = sum[7:0];
            flg[FLAG_OV] = (work_reg_i[7] == lo[7]) && (res[7] != lo[7]);
         end
         OP_LIT_SUB: begin
            // Carry set means no borrow
            sum = {1'b0, lo} + {1'b0, ~work_reg_i} + 9'h1;
            nib = {1'b0, lo[3:0]} + {1'b0, ~work_reg_i[3:0]} + 5'h1;
            res = sum[7:0];
            flg[FLAG_OV] = (lo[7] != work_reg_i[7]) && (res[7] != lo[7]);
         end
         OP_LIT_AND:   res = work_reg_i & lo;
         OP_LIT_OR:    res = work_reg_i | lo;
         OP_LIT_XOR:   res = work_reg_i ^ lo;
         OP_LIT_LOAD,
         OP_RET_LIT:   res = lo;
         OP_BIT_CLR:   res = file_data_i & ~(8'h01 << instr_i[11:9]);
         OP_BIT_SET:   res = file_data_i | (8'h01 << instr_i[11:9]);
         OP_BIT_TOG:   res = file_data_i ^ (8'h01 << instr_i[11:9]);
         OP_DEC_ADJ: begin
            if (work_reg_i[3:0] > 4'h9 || flags_i[FLAG_DC]) begin
               adj = adj + 9'h006;
            end
            if (adj[7:4] > 4'h9 || flags_i[FLAG_C] || adj[8]) begin
               adj = adj + 9'h060;
            end
            res = adj[7:0];
            flg[FLAG_C] = adj[8] || flags_i[FLAG_C];
         end
         default: res = work_reg_i;
      endcase
      if (d_op == OP_LIT_ADD || d_op == OP_LIT_SUB) begin
         flg[FLAG_C]  = sum[8];
         flg[FLAG_DC] = nib[4];
      end
      flg[FLAG_Z] = (d_mask[FLAG_Z]) ? (res == 8'h0) : flags_i[FLAG_Z];
      flg[FLAG_N] = (d_mask[FLAG_N]) ? res[7] : flags_i[FLAG_N];
   end

   // ****************
   // Sequencing
   // ****************
   logic       w1_ptr;
   logic [7:0] w1_lo;
   logic       sfr_hit;

   assign sfr_hit = (d_op == OP_BIT_CLR || d_op == OP_BIT_SET || d_op == OP_BIT_TOG)
                    && !instr_i[8];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state  <= ST_EXEC;
         w1_ptr <= 1'b0;
         w1_lo  <= 8'h0;
      end else if (instr_valid_i) begin
         case (state)
            ST_EXEC: begin
               if (go && d_two) begin
                  state  <= ST_OPERAND;
                  w1_ptr <= (d_op == OP_PTR_LOAD);
                  w1_lo  <= lo;
               end else if (go && (d_pc || d_skip)) begin
                  state <= ST_FILL;
               end
            end
            ST_OPERAND: state <= w1_ptr ? ST_EXEC : ST_FILL;
            default:    state <= ST_EXEC;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         op_o              <= OP_NOP;
         cycles_o          <= CYC_NONE;
         flag_mask_o       <= 5'h0;
         file_addr_o       <= 8'h0;
         access_bank_o     <= 1'b0;
         bit_sel_o         <= 3'h0;
         literal_o         <= 8'h0;
         offset_o          <= 11'h0;
         long_literal_o    <= 20'h0;
         sel_o             <= 2'h0;
         result_o          <= 8'h0;
         product_o         <= 16'h0;
         flags_o           <= 5'h0;
         pc_load_o         <= 1'b0;
         skip_o            <= 1'b0;
         pins_read_o       <= 1'b0;
         prescaler_clear_o <= 1'b0;
      end else begin
         pc_load_o         <= 1'b0;
         skip_o            <= 1'b0;
         pins_read_o       <= 1'b0;
         prescaler_clear_o <= 1'b0;
         if (instr_valid_i && state == ST_FILL) begin
            op_o     <= OP_FILL;
            cycles_o <= CYC_NONE;
         end else if (instr_valid_i && state == ST_OPERAND) begin
            op_o     <= OP_SECOND;
            cycles_o <= CYC_NONE;
            pc_load_o <= !w1_ptr;
            // Pointer load takes 4 bits from word one, jumps take 8
            long_literal_o <= w1_ptr ? {8'h0, w1_lo[3:0], lo}
                                     : {instr_i[11:0], w1_lo};
            sel_o <= w1_ptr ? w1_lo[5:4] : sel_o;
         end else if (instr_valid_i && !ctrl[CTRL_EN]) begin
            op_o     <= OP_NOP;
            cycles_o <= CYC_ONE;
         end else if (go) begin
            op_o          <= d_op;
            cycles_o      <= d_cyc;
            flag_mask_o   <= d_mask;
            file_addr_o   <= lo;
            access_bank_o <= !instr_i[8];
            bit_sel_o     <= instr_i[11:9];
            literal_o     <= lo;
            // Relative offsets stay signed; the core sign extends them
            offset_o      <= (hi == HI_REL) ? instr_i[10:0]
                                            : {{3{lo[7]}}, lo};
            // The absolute call keeps its save-select bit in bit 8, not bit 0
            sel_o         <= (d_op == OP_CALL_ABS) ? {1'b0, instr_i[8]} : instr_i[1:0];
            result_o      <= res;
            product_o     <= work_reg_i * lo;
            flags_o       <= flg;
            pc_load_o     <= d_pc;
            skip_o        <= d_skip;
            pins_read_o   <= sfr_hit && lo == port_adr;
            prescaler_clear_o <= sfr_hit && lo == timer_adr
                                 && ctrl[CTRL_PSA];
         end
      end
   end

   // ****************
   // Assertions
   // ****************
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_bit_clear_op: assert property (go && hi == HI_BCLR |=> op_o == OP_BIT_CLR)
      else $error("bit clear not decoded");
   a_prescaler_clr: assert property (prescaler_clear_o |-> $past(ctrl[CTRL_PSA])
      && file_addr_o == $past(timer_adr))
      else $error("prescaler cleared without cause");
   a_test_clr_skip: assert property (go && hi == HI_TCLR && !bit_val
      |=> skip_o && flag_mask_o == 5'h0 && state == ST_FILL)
      else $error("clear test did not skip");
   a_fill_after: assert property (instr_valid_i && state == ST_FILL
      |=> op_o == OP_FILL && cycles_o == CYC_NONE)
      else $error("skipped word not squashed");
   a_test_set_skip: assert property (go && hi == HI_TSET |=> skip_o == $past(bit_val))
      else $error("set test skip wrong");
   a_skip_cycles: assert property (skip_o |-> cycles_o == CYC_TWO)
      else $error("skip cycle count wrong");
   a_ext_word_nop: assert property (go && hi == HI_EXT |=> op_o == OP_NOP && !pc_load_o)
      else $error("lone second word acted");
   a_branch_taken: assert property (go && hi == HI_CTL && !instr_i[11]
      |=> pc_load_o == (cycles_o == CYC_TWO))
      else $error("branch cycles mismatch");
   a_jump_operand: assert property (instr_valid_i && state == ST_OPERAND && !w1_ptr
      |=> op_o == OP_SECOND && pc_load_o)
      else $error("jump second word lost");
   a_add_flags: assert property (go && instr_i[15:8] == 8'h0f
      |=> flag_mask_o == MASK_ALL && result_o == $past(work_reg_i + lo))
      else $error("literal add wrong");
   a_logic_flags: assert property (go && instr_i[15:8] == 8'h0b
      |=> flag_mask_o == MASK_ZN && flags_o[FLAG_Z] == (result_o == 8'h0))
      else $error("literal and flags wrong");
   a_table_cycles: assert property (go && instr_i[15:2] == 14'h0003
      |=> cycles_o == CYC_TWO && op_o == OP_TBL_WRITE)
      else $error("table write decode wrong");

   c_skip_fill: cover property (skip_o ##1 op_o == OP_FILL);
   c_call_abs:  cover property (op_o == OP_CALL_ABS ##[1:4] op_o == OP_SECOND);
   c_ptr_load:  cover property (op_o == OP_PTR_LOAD ##[1:4] op_o == OP_SECOND);
   c_presc_clr: cover property (prescaler_clear_o);
endmodule : bcld_decoder
`default_nettype wire

// file: hw/bcld_pkg.sv
// Constants, opcodes and register map of the literal and control decoder
package bcld_pkg;
   // ****************
   // Register map
   // ****************
   localparam logic [7:0]  ADR_CTRL    = 8'h00;
   localparam logic [7:0]  ADR_SFR     = 8'h04;
   localparam logic [7:0]  ADR_STATUS  = 8'h08;
   localparam logic [1:0]  CTRL_RST    = 2'h1;
   localparam int          CTRL_EN     = 0;
   localparam int          CTRL_PSA    = 1;
   localparam logic [7:0]  TIMER_ADR_RST = 8'h01;
   localparam logic [7:0]  PORT_ADR_RST  = 8'h02;
   // ****************
   // Flag positions
   // ****************
   localparam int          FLAG_C      = 0;
   localparam int          FLAG_DC     = 1;
   localparam int          FLAG_Z      = 2;
   localparam int          FLAG_OV     = 3;
   localparam int          FLAG_N      = 4;
   localparam logic [4:0]  MASK_ALL    = 5'h1f;
   localparam logic [4:0]  MASK_ZN     = 5'h14;
   localparam logic [4:0]  MASK_C      = 5'h01;
   // ****************
   // Encodings
   // ****************
   localparam logic [3:0]  HI_BCLR     = 4'h9;
   localparam logic [3:0]  HI_BSET     = 4'h8;
   localparam logic [3:0]  HI_BTOG     = 4'h7;
   localparam logic [3:0]  HI_TCLR     = 4'hb;
   localparam logic [3:0]  HI_TSET     = 4'ha;
   localparam logic [3:0]  HI_CTL      = 4'he;
   localparam logic [3:0]  HI_REL      = 4'hd;
   localparam logic [3:0]  HI_EXT      = 4'hf;
   localparam logic [3:0]  HI_LIT      = 4'h0;
   localparam logic [1:0]  CYC_NONE    = 2'h0;
   localparam logic [1:0]  CYC_ONE     = 2'h1;
   localparam logic [1:0]  CYC_TWO     = 2'h2;

   typedef enum logic [1:0] {
      ST_EXEC    = 2'b00,
      ST_OPERAND = 2'b01,
      ST_FILL    = 2'b10
   } bcld_state_type;

   typedef enum logic [5:0] {
      OP_NOP       = 6'b000000,
      OP_BIT_CLR   = 6'b000001,
      OP_BIT_SET   = 6'b000010,
      OP_BIT_TOG   = 6'b000011,
      OP_TEST_CLR  = 6'b000100,
      OP_TEST_SET  = 6'b000101,
      OP_BR_COND   = 6'b000110,
      OP_BR_ALWAYS = 6'b000111,
      OP_CALL_ABS  = 6'b001000,
      OP_CALL_REL  = 6'b001001,
      OP_JUMP_ABS  = 6'b001010,
      OP_STANDBY   = 6'b001011,
      OP_WDT_CLR   = 6'b001100,
      OP_SW_RESET  = 6'b001101,
      OP_PUSH      = 6'b001110,
      OP_POP       = 6'b001111,
      OP_IRQ_RET   = 6'b010000,
      OP_SUB_RET   = 6'b010001,
      OP_RET_LIT   = 6'b010010,
      OP_LIT_ADD   = 6'b010011,
      OP_LIT_SUB   = 6'b010100,
      OP_LIT_AND   = 6'b010101,
      OP_LIT_OR    = 6'b010110,
      OP_LIT_XOR   = 6'b010111,
      OP_LIT_LOAD  = 6'b011000,
      OP_LIT_MUL   = 6'b011001,
      OP_BANK_LOAD = 6'b011010,
      OP_PTR_LOAD  = 6'b011011,
      OP_TBL_READ  = 6'b011100,
      OP_TBL_WRITE = 6'b011101,
      OP_DEC_ADJ   = 6'b011110,
      OP_SECOND    = 6'b011111,
      OP_FILL      = 6'b100000,
      OP_OTHER     = 6'b111111
   } bcld_op_type;
endpackage : bcld_pkg

// file: tb/bcld_prog_mem.sv
// Program memory model that hands instruction words to the decoder
`timescale 1ns/10ps
`default_nettype none
module bcld_prog_mem (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        fetch_i,
   input  wire logic [15:0] word_i,
   output logic      [15:0] instr_o,
   output logic             instr_valid_o
);
   // Between fetches the word bus inverts every cycle, so a stale word never looks valid
   always_ff @(posedge clk_i) begin
      instr_valid_o <= fetch_i & ~rst_i;
      instr_o       <= rst_i ? 16'h0000 : (fetch_i ? word_i : ~instr_o);
   end
endmodule : bcld_prog_mem
`default_nettype wire

// file: tb/tb_bcld_decoder.sv
// Self-checking bench for the instruction decoder
`timescale 1ns/10ps
`default_nettype none
module tb_bcld_decoder;
   import bcld_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic fetch = 1'b0, instr_valid_i, wb_ack_o, access_bank_o, tk;
   logic pc_load_o, skip_o, pins_read_o, prescaler_clear_o;
   logic [7:0] wb_adr_i = 8'h00, file_data_i = 8'h03, work_reg_i = 8'h10;
   logic [7:0] file_addr_o, literal_o, result_o;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic [15:0] word = 16'h0, instr_i, product_o;
   logic [4:0] flags_i = 5'h15, flag_mask_o, flags_o;
   logic [1:0] cycles_o, sel_o;
   logic [2:0] bit_sel_o;
   logic [10:0] offset_o;
   logic [19:0] long_literal_o;
   bcld_op_type op_o;
   int miscompares = 0, check_count = 0;
   int fi [4] = '{2, 0, 3, 4};
   logic [15:0] lw [7] = '{16'h0f05, 16'h0b05, 16'h0905, 16'h0a05, 16'h0805, 16'h0e05, 16'h0d05};
   bcld_op_type lo [7] = '{OP_LIT_ADD, OP_LIT_AND, OP_LIT_OR, OP_LIT_XOR, OP_LIT_SUB,
      OP_LIT_LOAD, OP_LIT_MUL};
   logic [7:0] lr [5] = '{8'h15, 8'h00, 8'h15, 8'h15, 8'hf5};
   logic [4:0] lm [7] = '{5'h1f, 5'h14, 5'h14, 5'h14, 5'h1f, 5'h00, 5'h00};
   logic [4:0] lf [7] = '{5'h00, 5'h05, 5'h01, 5'h01, 5'h12, 5'h15, 5'h15};
   logic [15:0] cw [18] = '{16'h0003, 16'h0004, 16'h00ff, 16'h0005, 16'h0006, 16'h0000,
      16'h0007, 16'h0105, 16'h0008, 16'h000b, 16'h000c, 16'h000f, 16'h0010, 16'h0011,
      16'h0013, 16'h0c33, 16'hd7ff, 16'hd801};
   bcld_op_type co [18] = '{OP_STANDBY, OP_WDT_CLR, OP_SW_RESET, OP_PUSH, OP_POP, OP_NOP,
      OP_DEC_ADJ, OP_BANK_LOAD, OP_TBL_READ, OP_TBL_READ, OP_TBL_WRITE, OP_TBL_WRITE,
      OP_IRQ_RET, OP_IRQ_RET, OP_SUB_RET, OP_RET_LIT, OP_BR_ALWAYS, OP_CALL_REL};
   always #5 clk_i = ~clk_i;
   bcld_prog_mem mem (.clk_i, .rst_i, .fetch_i(fetch), .word_i(word), .instr_o(instr_i),
      .instr_valid_o(instr_valid_i));
   bcld_decoder dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .instr_i, .instr_valid_i,
      .file_data_i, .work_reg_i, .flags_i, .op_o, .cycles_o, .flag_mask_o, .file_addr_o,
      .access_bank_o, .bit_sel_o, .literal_o, .offset_o, .long_literal_o, .sel_o,
      .result_o, .product_o, .flags_o, .pc_load_o, .skip_o, .pins_read_o,
      .prescaler_clear_o);
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // Request held until ack is sampled at a rising edge
   task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wbx
   task automatic dec(input logic [15:0] w, input bcld_op_type o, input logic [1:0] c);
      @(posedge clk_i);
      fetch <= 1'b1;
      word <= w;
      @(posedge clk_i);
      fetch <= 1'b0;
      @(posedge clk_i);
      #1;
      chk("op", op_o, o);
      chk("cycles", cycles_o, c);
   endtask : dec
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   initial begin
      #60000;
      miscompares++;
      complete_run();
   end
   // ****************
   // Test sequence
   // ****************
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      wbx(1'b0, ADR_SFR, 32'h0);
      chk("sfr", rd, 32'h0201);
      wbx(1'b0, 8'h0c, 32'h0);
      chk("unmapped", rd, 32'h0);
      for (int i = 0; i < 7; i++) begin
         dec(lw[i], lo[i], CYC_ONE);
         chk("mask", flag_mask_o, lm[i]);
         if (i < 5) chk("result", result_o, lr[i]);
         chk("flags", flags_o, lf[i]);
         chk("literal", literal_o, 8'h05);
      end
      chk("product", product_o, 16'h0050);
      for (int i = 0; i < 18; i++) begin
         dec(cw[i], co[i], (i < 8) ? CYC_ONE : CYC_TWO);
         chk("pc_load", pc_load_o, i > 11);
         chk("sel", sel_o, cw[i][1:0]);
         if (i == 6) chk("mask", flag_mask_o, MASK_C);
         if (i > 11) dec(16'h0000, OP_FILL, CYC_NONE);
      end
      for (int c = 0; c < 8; c++) begin
         tk = flags_i[fi[c/2]] ^ c[0];
         dec({5'h1c, 3'(c), 8'hff}, OP_BR_COND, tk ? CYC_TWO : CYC_ONE);
         chk("offset", offset_o, 11'h7ff);
         if (tk) dec(16'h0000, OP_FILL, CYC_NONE);
      end
      dec(16'hb000, OP_TEST_CLR, CYC_ONE);
      chk("skip", skip_o, 1'b0);
      dec(16'hb400, OP_TEST_CLR, CYC_TWO);
      chk("mask", flag_mask_o, 5'h00);
      dec(16'hf123, OP_FILL, CYC_NONE);
      dec(16'ha200, OP_TEST_SET, CYC_TWO);
      chk("skip", skip_o, 1'b1);
      dec(16'hef00, OP_FILL, CYC_NONE);
      dec(16'hf000, OP_NOP, CYC_ONE);
      dec(16'h9300, OP_BIT_CLR, CYC_ONE);
      chk("result", result_o, 8'h01);
      dec(16'h8e05, OP_BIT_SET, CYC_ONE);
      chk("result", result_o, 8'h83);
      chk("addr", {access_bank_o, bit_sel_o, file_addr_o}, 12'hf05);
      dec(16'h7502, OP_BIT_TOG, CYC_ONE);
      chk("result", result_o, 8'h07);
      wbx(1'b1, ADR_CTRL, 32'h3);
      dec(16'h8001, OP_BIT_SET, CYC_ONE);
      chk("psc", prescaler_clear_o, 1'b1);
      dec(16'h8002, OP_BIT_SET, CYC_ONE);
      chk("pins", pins_read_o, 1'b1);
      dec(16'h8101, OP_BIT_SET, CYC_ONE);
      chk("psc", prescaler_clear_o, 1'b0);
      wbx(1'b1, ADR_SFR, 32'h0240);
      dec(16'h8040, OP_BIT_SET, CYC_ONE);
      chk("psc", prescaler_clear_o, 1'b1);
      wbx(1'b1, ADR_CTRL, 32'h2);
      dec(16'h0f05, OP_NOP, CYC_ONE);
      wbx(1'b1, ADR_CTRL, 32'h3);
      dec(16'hef12, OP_JUMP_ABS, CYC_TWO);
      dec(16'hf345, OP_SECOND, CYC_NONE);
      chk("long", {pc_load_o, long_literal_o}, 21'h134512);
      dec(16'h0000, OP_FILL, CYC_NONE);
      dec(16'hed12, OP_CALL_ABS, CYC_TWO);
      chk("sel", sel_o, 2'h1);
      dec(16'hf345, OP_SECOND, CYC_NONE);
      dec(16'hee12, OP_FILL, CYC_NONE);
      dec(16'hee12, OP_PTR_LOAD, CYC_TWO);
      dec(16'hf034, OP_SECOND, CYC_NONE);
      chk("long", {sel_o, long_literal_o}, 22'h100234);
      dec(16'h0f01, OP_LIT_ADD, CYC_ONE);
      wbx(1'b0, ADR_STATUS, 32'h0);
      chk("status", rd, {24'h0, CYC_ONE, OP_LIT_ADD});
      complete_run();
   end
endmodule : tb_bcld_decoder
`default_nettype wire
